// *** logic/resp_buffer.sv ***
`timescale 1ns/1ps
`include "usb_ep_map.svh"

module resp_buffer (
   input wire logic clock,
   input wire logic srst,
   resp_if.buffer port
);
   usb_ep_pkg::resp_t mem [0:`EP_BUF_DEPTH-1];
   logic wrPtr_reg;
   logic rdPtr_reg;
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic push;
   logic pop;
   logic inReady_reg;
   logic outValid_reg;
   logic rdPtr_next;
   usb_ep_pkg::resp_t outData_reg;

   assign push = port.inValid && inReady_reg;
   assign pop = port.outValid && port.outReady;
   assign port.inReady = inReady_reg;
   assign port.outValid = outValid_reg;
   assign port.outData = outData_reg;
   assign rdPtr_next = pop ? ~rdPtr_reg : rdPtr_reg;

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 2'h1;
      end else if (pop && !push) begin
         count_next = count_reg - 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wrPtr_reg <= 1'h0;
         rdPtr_reg <= 1'h0;
         count_reg <= 2'h0;
         inReady_reg <= 1'h1;
         outValid_reg <= 1'h0;
      end else begin
         if (push) begin
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (pop) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         count_reg <= count_next;
         inReady_reg <= (count_next != 2'h2);
         outValid_reg <= (count_next != 2'h0);
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_reg] <= port.inData;
      end
   end

   // Head kept in a register so the outputs come from flip-flops
   always_ff @(posedge clock) begin
      if (push && (wrPtr_reg == rdPtr_next)) begin
         outData_reg <= port.inData;
      end else begin
         outData_reg <= mem[rdPtr_next];
      end
   end
endmodule // resp_buffer

// *** logic/usb_endpoint_nak_pid_control.sv ***
// Functional notes
// [RULE1] Bit 17 reads 1 while NAKing, 0 while handshakes follow FIFO; resets 0.
// [RULE2] NAK state is set by software request or by the controller alike.
// [RULE3] OUT endpoint in NAK state accepts no data, even with FIFO room.
// [RULE4] Non-isochronous IN endpoint in NAK state sends no data, even if pending.
// [RULE5] Isochronous IN endpoint in NAK state answers each IN with zero-length packet.
// [RULE6] SETUP data is always acknowledged, whatever the NAK state.
// [RULE7] Bit 16 shows next data PID for interrupt and bulk endpoints; resets 0.
// [RULE8] Software sets the first data PID after enabling the endpoint.
// [RULE9] Force-DATA1 and force-DATA0 commands load the data PID field.
// [RULE10] For isochronous IN, bit 16 selects even or odd transmit frames.
// [RULE11] Software programs the frame parity for isochronous IN endpoints.
// [RULE12] Data PID field encodes DATA0 as 0 and DATA1 as 1.
// [RULE13] Each acknowledged interrupt or bulk transaction toggles the data PID.
`timescale 1ns/1ps
`include "usb_ep_map.svh"

module usb_endpoint_nak_pid_control (
   input wire logic clock,
   input wire logic srst,
   input wire usb_ep_pkg::ep_type_t epType,
   input wire logic epDirIn,
   input wire logic appSetNak,
   input wire logic appClearNak,
   input wire logic ctrlSetNak,
   input wire logic forceData0Pid,
   input wire logic forceData1Pid,
   input wire logic tokenValid,
   output logic tokenReady,
   input wire usb_ep_pkg::tok_t tokenKind,
   input wire logic frameOdd,
   input wire logic txFifoHasData,
   input wire logic rxFifoHasRoom,
   input wire logic hostAck,
   output logic respValid,
   input wire logic respReady,
   output usb_ep_pkg::resp_kind_t respKind,
   output logic respPid,
   output logic nakState,
   output logic dataPidSelect,
   output logic [`EP_STATUS_W-1:0] epStatus
);
   // ***************************************************
   // Declarations
   // ***************************************************
   resp_if respBus ();
   logic nakState_reg;
   logic nakState_next;
   logic pid_reg;
   logic pid_next;
   logic inFlight_reg;
   logic [`EP_STATUS_W-1:0] epStatus_reg;
   logic tokenTake;
   logic seqType;
   logic toggleNow;
   usb_ep_pkg::resp_t resp;

   assign tokenTake = tokenValid && respBus.inReady;
   assign seqType = (epType == usb_ep_pkg::EP_BULK) || (epType == usb_ep_pkg::EP_INTR);

   // ***************************************************
   // Response decision
   // ***************************************************
   always_comb begin
      resp.kind = usb_ep_pkg::RESP_NAK;
      resp.pid = `EP_PID_DATA0;
      case (tokenKind)
         usb_ep_pkg::TOK_SETUP: begin
            resp.kind = usb_ep_pkg::RESP_ACK; // see [RULE6]
         end
         usb_ep_pkg::TOK_OUT: begin
            if (!nakState_reg && rxFifoHasRoom) begin // see [RULE3]
               resp.kind = usb_ep_pkg::RESP_ACK;
            end
         end
         usb_ep_pkg::TOK_IN: begin
            if (epType == usb_ep_pkg::EP_ISO) begin
               resp.kind = usb_ep_pkg::RESP_ZLP; // see [RULE5]
               if (!nakState_reg && txFifoHasData && (frameOdd == pid_reg)) begin // see [RULE10]
                  resp.kind = usb_ep_pkg::RESP_DATA;
               end
            end else if (!nakState_reg && txFifoHasData) begin // see [RULE4]
               resp.kind = usb_ep_pkg::RESP_DATA;
               resp.pid = pid_reg; // see [RULE7]
            end
         end
         default: begin
            resp.kind = usb_ep_pkg::RESP_NAK;
         end
      endcase
   end

   assign respBus.inValid = tokenValid;
   assign respBus.inData = resp;
   assign respBus.outReady = respReady;

   resp_buffer respBuffer (
      .clock(clock),
      .srst(srst),
      .port(respBus)
   );

   // ***************************************************
   // NAK state
   // ***************************************************
   always_comb begin
      nakState_next = nakState_reg;
      if (appClearNak) begin
         nakState_next = 1'h0;
      end
      if (appSetNak || ctrlSetNak) begin // see [RULE2]
         nakState_next = 1'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         nakState_reg <= `EP_NAK_RST; // see [RULE1]
      end else begin
         nakState_reg <= nakState_next;
      end
   end

   // ***************************************************
   // Data PID and frame parity
   // ***************************************************
   assign toggleNow = seqType && ((hostAck && inFlight_reg) ||
      (tokenTake && tokenKind == usb_ep_pkg::TOK_OUT && resp.kind == usb_ep_pkg::RESP_ACK));

   always_comb begin
      pid_next = pid_reg;
      if (toggleNow) begin
         pid_next = ~pid_reg; // see [RULE13]
      end
      if (forceData1Pid) begin
         pid_next = `EP_PID_DATA1; // see [RULE9] [RULE12]
      end else if (forceData0Pid) begin
         pid_next = `EP_PID_DATA0; // see [RULE9] [RULE12]
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pid_reg <= `EP_PID_RST; // see [RULE7]
      end else begin
         pid_reg <= pid_next;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         inFlight_reg <= 1'h0;
      end else if (tokenTake) begin
         inFlight_reg <= epDirIn && seqType && (resp.kind == usb_ep_pkg::RESP_DATA);
      end else if (hostAck) begin
         inFlight_reg <= 1'h0;
      end
   end

   // ***************************************************
   // Status word
   // ***************************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         epStatus_reg <= '0;
      end else begin
         epStatus_reg <= '0;
         epStatus_reg[`EP_NAK_BIT] <= nakState_next; // see [RULE1]
         epStatus_reg[`EP_PID_BIT] <= pid_next; // see [RULE7] [RULE10]
      end
   end

   assign tokenReady = respBus.inReady;
   assign respValid = respBus.outValid;
   assign respKind = respBus.outData.kind;
   assign respPid = respBus.outData.pid;
   assign nakState = nakState_reg;
   assign dataPidSelect = pid_reg;
   assign epStatus = epStatus_reg;

   // ***************************************************
   // Checks
   // ***************************************************
   property p_nak_reset;
      @(posedge clock) srst |=> !nakState && !dataPidSelect;
   endproperty
   a_nak_reset: assert property (p_nak_reset) else $error("state not cleared by reset"); // see [RULE1]

   property p_nak_set;
      @(posedge clock) disable iff (srst)
         (appSetNak || ctrlSetNak) |=> nakState && epStatus[`EP_NAK_BIT];
   endproperty
   a_nak_set: assert property (p_nak_set) else $error("NAK request not taken"); // see [RULE2]

   property p_out_nak;
      @(posedge clock) disable iff (srst)
         tokenTake && nakState && tokenKind == usb_ep_pkg::TOK_OUT
         |-> resp.kind == usb_ep_pkg::RESP_NAK;
   endproperty
   a_out_nak: assert property (p_out_nak) else $error("OUT data taken while NAKing"); // see [RULE3]

   property p_in_nak;
      @(posedge clock) disable iff (srst)
         tokenTake && nakState && tokenKind == usb_ep_pkg::TOK_IN && epType != usb_ep_pkg::EP_ISO
         |-> resp.kind == usb_ep_pkg::RESP_NAK;
   endproperty
   a_in_nak: assert property (p_in_nak) else $error("IN data sent while NAKing"); // see [RULE4]

   property p_iso_zlp;
      @(posedge clock) disable iff (srst)
         tokenTake && nakState && tokenKind == usb_ep_pkg::TOK_IN && epType == usb_ep_pkg::EP_ISO
         |-> resp.kind == usb_ep_pkg::RESP_ZLP;
   endproperty
   a_iso_zlp: assert property (p_iso_zlp) else $error("isochronous NAK not zero length"); // see [RULE5]

   property p_setup_ack;
      @(posedge clock) disable iff (srst)
         tokenTake && tokenKind == usb_ep_pkg::TOK_SETUP |-> resp.kind == usb_ep_pkg::RESP_ACK;
   endproperty
   a_setup_ack: assert property (p_setup_ack) else $error("SETUP not acknowledged"); // see [RULE6]

   property p_force_pid;
      @(posedge clock) disable iff (srst)
         forceData1Pid |=> dataPidSelect == 1'h1 && epStatus[`EP_PID_BIT] == 1'h1;
   endproperty
   a_force_pid: assert property (p_force_pid) else $error("force DATA1 not loaded"); // see [RULE9]

   property p_force_pid0;
      @(posedge clock) disable iff (srst)
         forceData0Pid && !forceData1Pid |=> dataPidSelect == 1'h0;
   endproperty
   a_force_pid0: assert property (p_force_pid0) else $error("force DATA0 not loaded"); // see [RULE12]

   property p_toggle;
      @(posedge clock) disable iff (srst)
         hostAck && inFlight_reg && seqType && !forceData0Pid && !forceData1Pid
         |=> dataPidSelect != $past(dataPidSelect);
   endproperty
   a_toggle: assert property (p_toggle) else $error("data PID did not toggle"); // see [RULE13]
endmodule // usb_endpoint_nak_pid_control

// *** pkg/resp_if.sv ***
`timescale 1ns/1ps

interface resp_if;
   logic inValid;
   logic inReady;
   usb_ep_pkg::resp_t inData;
   logic outValid;
   logic outReady;
   usb_ep_pkg::resp_t outData;

   modport buffer (
      input inValid,
      output inReady,
      input inData,
      output outValid,
      input outReady,
      output outData
   );

   modport user (
      output inValid,
      input inReady,
      output inData,
      input outValid,
      output outReady,
      input outData
   );
endinterface

// *** pkg/usb_ep_map.svh ***
`ifndef USB_EP_MAP_SVH
`define USB_EP_MAP_SVH

// Endpoint control word field positions
`define EP_NAK_BIT 17
`define EP_PID_BIT 16
`define EP_STATUS_W 32

// Reset values
`define EP_NAK_RST 1'h0
`define EP_PID_RST 1'h0

// Data PID encoding
`define EP_PID_DATA0 1'h0
`define EP_PID_DATA1 1'h1

// Response buffer depth
`define EP_BUF_DEPTH 2

`endif

// *** pkg/usb_ep_pkg.sv ***
package usb_ep_pkg;

   typedef enum logic [1:0] {
      EP_CONTROL,
      EP_ISO,
      EP_BULK,
      EP_INTR
   } ep_type_t;

   typedef enum logic [1:0] {
      TOK_OUT,
      TOK_IN,
      TOK_SETUP
   } tok_t;

   typedef enum logic [1:0] {
      RESP_ACK,
      RESP_NAK,
      RESP_DATA,
      RESP_ZLP
   } resp_kind_t;

   typedef struct packed {
      resp_kind_t kind;
      logic pid;
   } resp_t;

endpackage

// *** testbench/host_model.sv ***
`timescale 1ns/1ps

module host_model (
   input wire logic clock,
   output logic tokenValid,
   input wire logic tokenReady,
   output usb_ep_pkg::tok_t tokenKind,
   input wire logic respValid,
   output logic respReady,
   input wire usb_ep_pkg::resp_kind_t respKind,
   input wire logic respPid,
   output logic hostAck
);
   int timeouts = 0;

   initial begin
      tokenValid = 1'b0;
      tokenKind = usb_ep_pkg::TOK_OUT;
      respReady = 1'b0;
      hostAck = 1'b0;
   end

   // Token held until taken, then scrambled
   task automatic send(input usb_ep_pkg::tok_t k);
      int n;
      n = 0;
      tokenValid <= 1'b1;
      tokenKind <= k;
      do begin
         @(posedge clock);
         n++;
      end while (tokenReady !== 1'b1 && n < 50);
      if (tokenReady !== 1'b1) begin
         timeouts++;
      end
      tokenValid <= 1'b0;
      tokenKind <= usb_ep_pkg::tok_t'(~k);
   endtask

   task automatic take(input int stall, input logic ack,
         output usb_ep_pkg::resp_kind_t rk, output logic rp);
      int n;
      n = 0;
      repeat (stall) @(posedge clock);
      respReady <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (respValid !== 1'b1 && n < 50);
      if (respValid !== 1'b1) begin
         timeouts++;
      end
      rk = respKind;
      rp = respPid;
      respReady <= 1'b0;
      if (ack && rk == usb_ep_pkg::RESP_DATA) begin
         hostAck <= 1'b1;
         @(posedge clock);
         hostAck <= 1'b0;
      end
   endtask
endmodule // host_model

// *** testbench/usb_endpoint_nak_pid_control_tb_top.sv ***
`timescale 1ns/1ps

module usb_endpoint_nak_pid_control_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   usb_ep_pkg::ep_type_t epType = usb_ep_pkg::EP_BULK;
   logic epDirIn = 1'b1;
   logic appSetNak = 1'b0;
   logic appClearNak = 1'b0;
   logic ctrlSetNak = 1'b0;
   logic forceData0Pid = 1'b0;
   logic forceData1Pid = 1'b0;
   logic frameOdd = 1'b0;
   logic txFifoHasData = 1'b1;
   logic rxFifoHasRoom = 1'b1;
   logic tokenValid, tokenReady, respValid, respReady, hostAck, respPid, rp;
   logic nakState, dataPidSelect;
   logic [31:0] epStatus;
   usb_ep_pkg::tok_t tokenKind;
   usb_ep_pkg::resp_kind_t respKind, rk;
   int miscompares = 0;
   int totalChecks = 0;

   always #25 clock = ~clock;

   usb_endpoint_nak_pid_control uut (.clock(clock), .srst(srst), .epType(epType),
      .epDirIn(epDirIn), .appSetNak(appSetNak), .appClearNak(appClearNak),
      .ctrlSetNak(ctrlSetNak), .forceData0Pid(forceData0Pid),
      .forceData1Pid(forceData1Pid), .tokenValid(tokenValid), .tokenReady(tokenReady),
      .tokenKind(tokenKind), .frameOdd(frameOdd), .txFifoHasData(txFifoHasData),
      .rxFifoHasRoom(rxFifoHasRoom), .hostAck(hostAck), .respValid(respValid),
      .respReady(respReady), .respKind(respKind), .respPid(respPid),
      .nakState(nakState), .dataPidSelect(dataPidSelect), .epStatus(epStatus));

   host_model host (.clock(clock), .tokenValid(tokenValid), .tokenReady(tokenReady),
      .tokenKind(tokenKind), .respValid(respValid), .respReady(respReady),
      .respKind(respKind), .respPid(respPid), .hostAck(hostAck));

   // ****************
   // Tasks
   // ****************
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tick;
      @(posedge clock);
   endtask

   task strobe(input int s);
      case (s)
         0: appSetNak <= 1'b1;
         1: appClearNak <= 1'b1;
         2: ctrlSetNak <= 1'b1;
         3: forceData0Pid <= 1'b1;
         5: {appSetNak, appClearNak} <= 2'h3;
         6: {forceData0Pid, forceData1Pid} <= 2'h3;
         default: forceData1Pid <= 1'b1;
      endcase
      tick;
      {appSetNak, appClearNak, ctrlSetNak, forceData0Pid, forceData1Pid} <= 5'h00;
      tick;
   endtask

   task io(input usb_ep_pkg::tok_t k, input usb_ep_pkg::resp_kind_t ek, input logic ep);
      host.send(k);
      host.take(0, 1'b1, rk, rp);
      check("respKind", rk, ek);
      check("respPid", rp, ep);
      tick;
   endtask

   task stat(input logic n, input logic p);
      check("nakState", nakState, n);
      check("dataPidSelect", dataPidSelect, p);
      check("epStatus", epStatus, {14'h0000, n, p, 16'h0000});
   endtask

   task give_verdict;
      miscompares += host.timeouts;
      $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge clock);
      miscompares++;
      give_verdict;
   end

   // ****************
   // Tests
   // ****************
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      stat(1'b0, 1'b0);
      $display("Test reset done");
      strobe(4);
      stat(1'b0, 1'b1);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_DATA, 1'b1);
      stat(1'b0, 1'b0);
      strobe(2);
      stat(1'b1, 1'b0);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_NAK, 1'b0);
      io(usb_ep_pkg::TOK_SETUP, usb_ep_pkg::RESP_ACK, 1'b0);
      strobe(1);
      strobe(4);
      stat(1'b0, 1'b1);
      strobe(3);
      stat(1'b0, 1'b0);
      $display("Test bulk in done");
      epDirIn <= 1'b0;
      epType <= usb_ep_pkg::EP_INTR;
      tick;
      io(usb_ep_pkg::TOK_OUT, usb_ep_pkg::RESP_ACK, 1'b0);
      stat(1'b0, 1'b1);
      strobe(0);
      io(usb_ep_pkg::TOK_OUT, usb_ep_pkg::RESP_NAK, 1'b0);
      stat(1'b1, 1'b1);
      strobe(1);
      rxFifoHasRoom <= 1'b0;
      tick;
      io(usb_ep_pkg::TOK_OUT, usb_ep_pkg::RESP_NAK, 1'b0);
      $display("Test out done");
      epType <= usb_ep_pkg::EP_ISO;
      epDirIn <= 1'b1;
      rxFifoHasRoom <= 1'b1;
      strobe(3);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_DATA, 1'b0);
      frameOdd <= 1'b1;
      tick;
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_ZLP, 1'b0);
      strobe(4);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_DATA, 1'b0);
      stat(1'b0, 1'b1);
      strobe(0);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_ZLP, 1'b0);
      $display("Test iso done");
      host.send(usb_ep_pkg::TOK_SETUP);
      tick;
      host.send(usb_ep_pkg::TOK_IN);
      tick;
      check("tokenReady", tokenReady, 1'b0);
      host.take(2, 1'b0, rk, rp);
      check("respKind", rk, usb_ep_pkg::RESP_ACK);
      tick;
      check("respValid", respValid, 1'b1);
      host.take(2, 1'b0, rk, rp);
      check("respKind", rk, usb_ep_pkg::RESP_ZLP);
      tick;
      check("tokenReady", tokenReady, 1'b1);
      check("respValid", respValid, 1'b0);
      $display("Test buffer done");
      strobe(1);
      strobe(5);
      stat(1'b1, 1'b1);
      strobe(1);
      epType <= usb_ep_pkg::EP_BULK;
      txFifoHasData <= 1'b0;
      tick;
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_NAK, 1'b0);
      txFifoHasData <= 1'b1;
      epType <= usb_ep_pkg::EP_CONTROL;
      strobe(3);
      strobe(6);
      stat(1'b0, 1'b1);
      io(usb_ep_pkg::TOK_IN, usb_ep_pkg::RESP_DATA, 1'b1);
      stat(1'b0, 1'b1);
      strobe(0);
      host.send(usb_ep_pkg::TOK_SETUP);
      srst <= 1'b1;
      repeat (2) tick;
      srst <= 1'b0;
      tick;
      stat(1'b0, 1'b0);
      check("respValid", respValid, 1'b0);
      check("tokenReady", tokenReady, 1'b1);
      io(usb_ep_pkg::TOK_SETUP, usb_ep_pkg::RESP_ACK, 1'b0);
      $display("Test extra done");
      give_verdict;
   end
endmodule // usb_endpoint_nak_pid_control_tb_top
